/* File: ahcc_clock_control.v */
// clock-control register bank: source muxes, slow clock, clock outputs and APB slave
//
// Local design decision: the APB slave port.
`include "ahcc_regs.vh"

module ahcc_clock_control (
  input wire mclk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [2:0] referenceInput,
  input wire [2:0] serialPortBitClock,
  input wire lockLoopOneDoubledTick,
  input wire lockLoopTwoDoubledTick,
  input wire lockLoopOneTripledTick,
  input wire lockLoopTwoTripledTick,
  input wire lockLoopOneTick,
  output reg primaryCoreTick,
  output reg secondaryCoreTick,
  output reg processorClockTick,
  output reg slowClockTick,
  output reg primaryClockOutput,
  output reg secondaryClockOutput,
  output reg primaryFamily44k,
  output reg secondaryFamily44k,
  output reg referenceThreePulldown
);

  // control fields
  reg slowClockEnable;
  reg [1:0] slowClockSource;
  reg primaryClockFamily;
  reg [2:0] primaryClockRateCode;
  reg primaryClockEnable;
  reg [3:0] primaryClockSource;
  reg [2:0] secondaryClockRateCode;
  reg secondaryClockEnable;
  reg [3:0] secondaryClockSource;
  reg processorClockEnable;
  reg [3:0] processorClockSource;
  reg [15:0] processorClockRate;
  reg [15:0] processorClockRateState;
  reg [1:0] outputEnable;
  reg [9:0] outputDivider;
  reg [5:0] outputSourceRate;
  reg [4:0] primarySel [0:2];
  reg [4:0] secondarySel [0:1];
  reg [4:0] primaryState [0:2];
  reg [4:0] secondaryState [0:1];

  // pin synchronisers and edge events
  reg [5:0] pinSyncA;
  reg [5:0] pinSyncB;
  reg [5:0] pinSyncC;
  reg [5:0] pinLevel;
  wire [5:0] pinRise;
  wire [5:0] pinRaw;
  wire [2:0] refRise;
  wire [2:0] bitRise;

  // bus decode
  wire [9:0] regIndex;
  wire setupPhase;
  wire writeTake;
  reg [15:0] readValue;
  reg readHit;

  // slow divider
  reg [15:0] slowCount;
  reg [15:0] slowLimit;
  reg next_slowTick;

  // clock output dividers
  wire [1:0] coreTick;
  reg [1:0] outLevel;
  reg [1:0] curEnable;
  reg [7:0] curHalf;
  reg [7:0] halfCount;

  integer k;
  integer j; // loop index of the rate-state process

  // pick one edge event from the source code; reserved codes yield none
  function srcTick;
    input [3:0] code;
    input [2:0] refs;
    input [2:0] bits;
    input loopA;
    input loopB;
    input loopRaw;
    begin
      case (code)
        `AHCC_SRC_REF1: srcTick = refs[0];
        `AHCC_SRC_REF2: srcTick = refs[1];
        `AHCC_SRC_REF3: srcTick = refs[2];
        `AHCC_SRC_LL1M: srcTick = loopA;
        `AHCC_SRC_LL2M: srcTick = loopB;
        `AHCC_SRC_BIT1: srcTick = bits[0];
        `AHCC_SRC_BIT2: srcTick = bits[1];
        `AHCC_SRC_BIT3: srcTick = bits[2];
        `AHCC_SRC_LL1: srcTick = loopRaw;
        default: srcTick = 1'b0;
      endcase
    end
  endfunction

  // half period in core ticks; reserved codes below two act as divide by two
  function [3:0] halfOf;
    input [4:0] div;
    begin
      halfOf = (div[4:1] == 4'h0) ? 4'h1 : div[4:1];
    end
  endfunction

  // rate codes 01XXX belong to the 44.1 kHz family
  function isFamily44k;
    input [4:0] sel;
    begin
      isFamily44k = (sel[4:3] == 2'b01);
    end
  endfunction

  assign pinRaw = {serialPortBitClock, referenceInput};

  // three-stage synchroniser; a change counts once stages two and three agree
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pinSyncA <= 6'h00;
      pinSyncB <= 6'h00;
      pinSyncC <= 6'h00;
      pinLevel <= 6'h00;
    end else begin
      pinSyncA <= pinRaw;
      pinSyncB <= pinSyncA;
      pinSyncC <= pinSyncB;
      // filtered level moves only when the last two stages agree
      pinLevel <= (pinSyncB & pinSyncC) | (pinLevel & (pinSyncB | pinSyncC));
    end
  end

  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : gen_edge
      assign pinRise[g] = pinSyncB[g] & pinSyncC[g] & ~pinLevel[g];
    end
  endgenerate

  assign refRise = pinRise[2:0];
  assign bitRise = pinRise[5:3];

  assign regIndex = paddr[11:2];
  assign setupPhase = psel & ~penable;
  assign writeTake = psel & penable & pready & pwrite;

  // read decode; unmapped indexes and upper address bits raise an error
  always @* begin
    readValue = 16'h0000;
    readHit = (paddr[31:12] == 20'h00000) && (paddr[1:0] == 2'b00);
    case (regIndex)
      `AHCC_IDX_SLOW_CTRL: readValue = {9'h000, slowClockEnable, 4'h0, slowClockSource};
      `AHCC_IDX_PRIM_CTRL: readValue = {primaryClockFamily, 4'h0, primaryClockRateCode, 1'b0,
                                        primaryClockEnable, 2'b00, primaryClockSource};
      `AHCC_IDX_PRIM_SEL1: readValue = {11'h000, primarySel[0]};
      `AHCC_IDX_PRIM_SEL2: readValue = {11'h000, primarySel[1]};
      `AHCC_IDX_PRIM_SEL3: readValue = {11'h000, primarySel[2]};
      `AHCC_IDX_PRIM_STA1: readValue = {11'h000, primaryState[0]};
      `AHCC_IDX_PRIM_STA2: readValue = {11'h000, primaryState[1]};
      `AHCC_IDX_PRIM_STA3: readValue = {11'h000, primaryState[2]};
      `AHCC_IDX_SEC_CTRL: readValue = {5'h00, secondaryClockRateCode, 1'b0, secondaryClockEnable,
                                       2'b00, secondaryClockSource};
      `AHCC_IDX_SEC_SEL1: readValue = {11'h000, secondarySel[0]};
      `AHCC_IDX_SEC_SEL2: readValue = {11'h000, secondarySel[1]};
      `AHCC_IDX_SEC_STA1: readValue = {11'h000, secondaryState[0]};
      `AHCC_IDX_SEC_STA2: readValue = {11'h000, secondaryState[1]};
      `AHCC_IDX_PROC_CTRL: readValue = {9'h000, processorClockEnable, 2'b00, processorClockSource};
      `AHCC_IDX_PROC_RATE: readValue = processorClockRate;
      `AHCC_IDX_PROC_RSTA: readValue = processorClockRateState;
      `AHCC_IDX_PROC_SSTA: readValue = {12'h000, processorClockSource};
      `AHCC_IDX_OUT1_CTRL: readValue = {outputEnable[0], 7'h00, outputDivider[4:0], outputSourceRate[2:0]};
      `AHCC_IDX_OUT2_CTRL: readValue = {outputEnable[1], 7'h00, outputDivider[9:5], outputSourceRate[5:3]};
      `AHCC_IDX_PAD_CTRL: readValue = {6'h00, referenceThreePulldown, 9'h000};
      default: readHit = 1'b0;
    endcase
  end

  // apb answer: one wait-free access cycle after setup, data captured in setup
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= setupPhase;
      if (setupPhase) begin
        prdata <= (readHit && !pwrite) ? {16'h0000, readValue} : 32'h00000000;
        pslverr <= ~readHit;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // writable fields; read-only registers ignore writes
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      slowClockEnable <= 1'b0;
      slowClockSource <= `AHCC_RST_SLOW_SRC;
      primaryClockFamily <= 1'b0;
      primaryClockRateCode <= `AHCC_RST_PRIM_RATE;
      primaryClockEnable <= 1'b0;
      primaryClockSource <= `AHCC_RST_PRIM_SRC;
      secondaryClockRateCode <= `AHCC_RST_SEC_RATE;
      secondaryClockEnable <= 1'b0;
      secondaryClockSource <= `AHCC_RST_SEC_SRC;
      processorClockEnable <= 1'b0;
      processorClockSource <= `AHCC_RST_PROC_SRC;
      processorClockRate <= 16'h0000;
      processorClockRateState <= 16'h0000;
      outputEnable <= 2'b00;
      outputDivider <= 10'h000;
      outputSourceRate <= 6'h00;
      referenceThreePulldown <= 1'b0;
      for (k = 0; k < 3; k = k + 1) begin
        primarySel[k] <= `AHCC_RST_SEL;
      end
      for (k = 0; k < 2; k = k + 1) begin
        secondarySel[k] <= `AHCC_RST_SEL;
      end
    end else if (writeTake && readHit) begin
      case (regIndex)
        `AHCC_IDX_SLOW_CTRL: begin
          slowClockEnable <= pwdata[`AHCC_ENA_BIT];
          slowClockSource <= pwdata[1:0];
        end
        // family, rate and source land together so a live change is one step
        `AHCC_IDX_PRIM_CTRL: begin
          primaryClockFamily <= pwdata[`AHCC_FAMILY_BIT];
          primaryClockRateCode <= pwdata[10:8];
          primaryClockEnable <= pwdata[`AHCC_ENA_BIT];
          primaryClockSource <= pwdata[3:0];
        end
        `AHCC_IDX_PRIM_SEL1: primarySel[0] <= pwdata[4:0];
        `AHCC_IDX_PRIM_SEL2: primarySel[1] <= pwdata[4:0];
        `AHCC_IDX_PRIM_SEL3: primarySel[2] <= pwdata[4:0];
        `AHCC_IDX_SEC_CTRL: begin
          secondaryClockRateCode <= pwdata[10:8];
          secondaryClockEnable <= pwdata[`AHCC_ENA_BIT];
          secondaryClockSource <= pwdata[3:0];
        end
        `AHCC_IDX_SEC_SEL1: secondarySel[0] <= pwdata[4:0];
        `AHCC_IDX_SEC_SEL2: secondarySel[1] <= pwdata[4:0];
        // a source write makes the pending processor rate active
        `AHCC_IDX_PROC_CTRL: begin
          processorClockEnable <= pwdata[`AHCC_ENA_BIT];
          processorClockSource <= pwdata[3:0];
          processorClockRateState <= processorClockRate;
        end
        // while running, a new rate waits for the next source write
        `AHCC_IDX_PROC_RATE: begin
          processorClockRate <= pwdata[15:0];
          if (!processorClockEnable) begin
            processorClockRateState <= pwdata[15:0];
          end
        end
        `AHCC_IDX_OUT1_CTRL: begin
          outputEnable[0] <= pwdata[`AHCC_OUT_ENA_BIT];
          outputDivider[4:0] <= pwdata[7:3];
          outputSourceRate[2:0] <= pwdata[2:0];
        end
        `AHCC_IDX_OUT2_CTRL: begin
          outputEnable[1] <= pwdata[`AHCC_OUT_ENA_BIT];
          outputDivider[9:5] <= pwdata[7:3];
          outputSourceRate[5:3] <= pwdata[2:0];
        end
        `AHCC_IDX_PAD_CTRL: referenceThreePulldown <= pwdata[`AHCC_PULLDOWN_BIT];
        default: begin
        end
      endcase
    end
  end

  // rate states mirror the selects only while their domain runs
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (j = 0; j < 3; j = j + 1) begin
        primaryState[j] <= `AHCC_RST_STATE;
      end
      for (j = 0; j < 2; j = j + 1) begin
        secondaryState[j] <= `AHCC_RST_STATE;
      end
    end else begin
      for (j = 0; j < 3; j = j + 1) begin
        primaryState[j] <= primaryClockEnable ? primarySel[j] : `AHCC_RST_STATE;
      end
      for (j = 0; j < 2; j = j + 1) begin
        secondaryState[j] <= secondaryClockEnable ? secondarySel[j] : `AHCC_RST_STATE;
      end
    end
  end

  // domain ticks; muxing single-cycle events cannot make a runt on a source change
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      primaryCoreTick <= 1'b0;
      secondaryCoreTick <= 1'b0;
      processorClockTick <= 1'b0;
      primaryFamily44k <= 1'b0;
      secondaryFamily44k <= 1'b0;
    end else begin
      primaryCoreTick <= primaryClockEnable & srcTick(primaryClockSource, refRise, bitRise,
        lockLoopOneDoubledTick, lockLoopTwoDoubledTick, lockLoopOneTick);
      secondaryCoreTick <= secondaryClockEnable & srcTick(secondaryClockSource, refRise, bitRise,
        lockLoopOneDoubledTick, lockLoopTwoDoubledTick, lockLoopOneTick);
      processorClockTick <= processorClockEnable & srcTick(processorClockSource, refRise, bitRise,
        lockLoopOneTripledTick, lockLoopTwoTripledTick, lockLoopOneTick);
      primaryFamily44k <= primaryClockFamily | isFamily44k(primarySel[0]);
      secondaryFamily44k <= isFamily44k(secondarySel[0]);
    end
  end

  // slow divider limit follows rate code and family of the primary clock
  always @* begin
    slowLimit = (primaryClockFamily ? `AHCC_SLOW_BASE_44K : `AHCC_SLOW_BASE_48K) << primaryClockRateCode;
    case (slowClockSource)
      2'b00: next_slowTick = refRise[0];
      2'b01: next_slowTick = refRise[1];
      2'b10: next_slowTick = primaryCoreTick && (slowCount == slowLimit - 16'h0001);
      default: next_slowTick = 1'b0;
    endcase
  end

  // slow clock only ticks while enabled
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      slowCount <= 16'h0000;
      slowClockTick <= 1'b0;
    end else begin
      slowClockTick <= slowClockEnable & next_slowTick;
      if (!slowClockEnable || slowClockSource != 2'b10) begin
        slowCount <= 16'h0000;
      end else if (primaryCoreTick) begin
        if (slowCount >= slowLimit - 16'h0001) begin
          slowCount <= 16'h0000;
        end else begin
          slowCount <= slowCount + 16'h0001;
        end
      end
    end
  end

  assign coreTick = {secondaryCoreTick, primaryCoreTick};

  // output dividers: new settings load only at the end of a low phase, so every
  // high and low half is whole; a stopped core freezes the pin where it stands
  generate
    for (g = 0; g < 2; g = g + 1) begin : gen_out
      always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          outLevel[g] <= 1'b0;
          curEnable[g] <= 1'b0;
          curHalf[g*4 +: 4] <= 4'h1;
          halfCount[g*4 +: 4] <= 4'h0;
        end else if (coreTick[g]) begin
          if (halfCount[g*4 +: 4] >= curHalf[g*4 +: 4] - 4'h1) begin
            halfCount[g*4 +: 4] <= 4'h0;
            if (outLevel[g]) begin
              outLevel[g] <= 1'b0;
            end else begin
              curEnable[g] <= outputEnable[g];
              curHalf[g*4 +: 4] <= halfOf(outputDivider[g*5 +: 5]);
              outLevel[g] <= outputEnable[g];
            end
          end else begin
            halfCount[g*4 +: 4] <= halfCount[g*4 +: 4] + 4'h1;
          end
        end else if (!outputEnable[g] && !outLevel[g]) begin
          curEnable[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // pins driven from flops, low after a disable once the current high half has ended
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      primaryClockOutput <= 1'b0;
      secondaryClockOutput <= 1'b0;
    end else begin
      primaryClockOutput <= outLevel[0] & curEnable[0];
      secondaryClockOutput <= outLevel[1] & curEnable[1];
    end
  end

endmodule

/* File: ahcc_clock_control_sva.sv */
// protocol and behaviour checker for the clock-control bank, bound to its ports
module ahcc_clock_control_sva (
  input wire mclk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire lockLoopOneDoubledTick,
  input wire lockLoopOneTripledTick,
  input wire lockLoopTwoTripledTick,
  input wire primaryCoreTick,
  input wire processorClockTick,
  input wire slowClockTick,
  input wire primaryClockOutput,
  input wire referenceThreePulldown
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic wrAcc;
  logic [9:0] idx;
  logic [15:0] slowSh, primSh, procSh;
  logic [3:0] slowOff, primOff;
  assign wrAcc = psel && penable && pready && pwrite && !pslverr;
  assign idx = paddr[11:2];
  // shadow copies of control words; off counters give slack for ticks already in the sync pipe
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      slowSh <= 16'h0002;
      primSh <= 16'h0404;
      procSh <= 16'h0005;
      slowOff <= 4'h0;
      primOff <= 4'h0;
    end else begin
      if (wrAcc && idx == 10'h100) slowSh <= pwdata[15:0];
      if (wrAcc && idx == 10'h101) primSh <= pwdata[15:0];
      if (wrAcc && idx == 10'h120) procSh <= pwdata[15:0];
      slowOff <= slowSh[6] ? 4'h0 : (slowOff == 4'hF ? slowOff : slowOff + 4'h1);
      primOff <= primSh[6] ? 4'h0 : (primOff == 4'hF ? primOff : primOff + 4'h1);
    end
  end
  a_ready_after_setup: assert property ((psel && !penable) |=> pready) else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held too long");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_err_read_zero: assert property ((pslverr && !pwrite) |-> prdata == 32'h0) else $error("error read not zero");
  a_upper_zero: assert property ((pready && !pwrite) |-> prdata[31:16] == 16'h0) else $error("upper read bits set");
  a_pulldown_follows: assert property ((wrAcc && idx == 10'h14E) |-> ##2
    referenceThreePulldown == $past(pwdata[9], 2)) else $error("pulldown not following pad bit");
  a_slow_quiet_off: assert property (slowClockTick |-> slowOff < 4'h6) else $error("slow tick while off");
  a_prim_quiet_off: assert property (primaryCoreTick |-> primOff < 4'h6) else $error("primary tick while off");
  a_prim_loop_tick: assert property ((primSh[6] && primSh[3:0] == 4'h4 && lockLoopOneDoubledTick)
    |=> primaryCoreTick) else $error("primary tick missing");
  a_proc_loop_tick: assert property ((procSh[6] && ((procSh[3:0] == 4'h4 && lockLoopOneTripledTick) ||
    (procSh[3:0] == 4'h5 && lockLoopTwoTripledTick))) |=> processorClockTick) else $error("processor tick missing");
  c_slow: cover property (slowClockTick);
  c_err: cover property (pslverr);
  c_out: cover property ($rose(primaryClockOutput));
endmodule

bind ahcc_clock_control ahcc_clock_control_sva chk (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .lockLoopOneDoubledTick(lockLoopOneDoubledTick), .lockLoopOneTripledTick(lockLoopOneTripledTick),
  .lockLoopTwoTripledTick(lockLoopTwoTripledTick), .primaryCoreTick(primaryCoreTick),
  .processorClockTick(processorClockTick), .slowClockTick(slowClockTick),
  .primaryClockOutput(primaryClockOutput), .referenceThreePulldown(referenceThreePulldown));

/* File: ahcc_regs.vh */
// register indexes, field positions, reset values and timing counts for the clock-control bank
`ifndef AHCC_REGS_VH
`define AHCC_REGS_VH

// register indexes; byte address is four times the index
`define AHCC_IDX_SLOW_CTRL 10'h100
`define AHCC_IDX_PRIM_CTRL 10'h101
`define AHCC_IDX_PRIM_SEL1 10'h102
`define AHCC_IDX_PRIM_SEL2 10'h103
`define AHCC_IDX_PRIM_SEL3 10'h104
`define AHCC_IDX_PRIM_STA1 10'h10A
`define AHCC_IDX_PRIM_STA2 10'h10B
`define AHCC_IDX_PRIM_STA3 10'h10C
`define AHCC_IDX_SEC_CTRL 10'h112
`define AHCC_IDX_SEC_SEL1 10'h113
`define AHCC_IDX_SEC_SEL2 10'h114
`define AHCC_IDX_SEC_STA1 10'h11B
`define AHCC_IDX_SEC_STA2 10'h11C
`define AHCC_IDX_PROC_CTRL 10'h120
`define AHCC_IDX_PROC_RATE 10'h122
`define AHCC_IDX_PROC_RSTA 10'h126
`define AHCC_IDX_PROC_SSTA 10'h127
`define AHCC_IDX_OUT1_CTRL 10'h149
`define AHCC_IDX_OUT2_CTRL 10'h14A
`define AHCC_IDX_PAD_CTRL 10'h14E

// field positions
`define AHCC_ENA_BIT 6
`define AHCC_FAMILY_BIT 15
`define AHCC_OUT_ENA_BIT 15
`define AHCC_PULLDOWN_BIT 9

// reset values
`define AHCC_RST_SLOW_SRC 2'h2
`define AHCC_RST_PRIM_RATE 3'h4
`define AHCC_RST_PRIM_SRC 4'h4
`define AHCC_RST_SEC_RATE 3'h3
`define AHCC_RST_SEC_SRC 4'h5
`define AHCC_RST_PROC_SRC 4'h5
`define AHCC_RST_SEL 5'h11
`define AHCC_RST_STATE 5'h00

// source codes
`define AHCC_SRC_REF1 4'h0
`define AHCC_SRC_REF2 4'h1
`define AHCC_SRC_REF3 4'h2
`define AHCC_SRC_LL1M 4'h4
`define AHCC_SRC_LL2M 4'h5
`define AHCC_SRC_BIT1 4'h8
`define AHCC_SRC_BIT2 4'h9
`define AHCC_SRC_BIT3 4'hA
`define AHCC_SRC_LL1 4'hF

// slow clock: primary ticks per slow tick at the lowest rate code, per family
`define AHCC_SLOW_BASE_48K 16'h00C0
`define AHCC_SLOW_BASE_44K 16'h00B0
`endif

/* File: test_ahcc_clock_control.sv */
// register-level testbench for the clock-control bank
module test_ahcc_clock_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, rst_n, psel, penable, pwrite, tog, errv;
  logic [31:0] paddr, pwdata, rdv;
  logic [3:0] pstrb;
  logic [2:0] referenceInput, serialPortBitClock;
  logic lockLoopOneDoubledTick, lockLoopOneTick;
  wire [31:0] prdata;
  wire pready, pslverr, primaryCoreTick, secondaryCoreTick, processorClockTick, slowClockTick;
  wire primaryClockOutput, secondaryClockOutput, primaryFamily44k, secondaryFamily44k, referenceThreePulldown;
  int n_mismatch, comparisons, i;
  logic [9:0] ridx [20] = '{10'h100, 10'h101, 10'h102, 10'h103, 10'h104, 10'h10A, 10'h10B, 10'h10C, 10'h112,
    10'h113, 10'h114, 10'h11B, 10'h11C, 10'h120, 10'h122, 10'h126, 10'h127, 10'h149, 10'h14A, 10'h14E};
  logic [15:0] rval [20] = '{16'h0002, 16'h0404, 16'h0011, 16'h0011, 16'h0011, 16'h0000, 16'h0000, 16'h0000,
    16'h0305, 16'h0011, 16'h0011, 16'h0000, 16'h0000, 16'h0005, 16'h0000, 16'h0000, 16'h0005, 16'h0000,
    16'h0000, 16'h0000};

  ahcc_clock_control dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .referenceInput(referenceInput), .serialPortBitClock(serialPortBitClock),
    .lockLoopOneDoubledTick(lockLoopOneDoubledTick), .lockLoopTwoDoubledTick(tog),
    .lockLoopOneTripledTick(tog), .lockLoopTwoTripledTick(tog), .lockLoopOneTick(lockLoopOneTick),
    .primaryCoreTick(primaryCoreTick), .secondaryCoreTick(secondaryCoreTick),
    .processorClockTick(processorClockTick), .slowClockTick(slowClockTick),
    .primaryClockOutput(primaryClockOutput), .secondaryClockOutput(secondaryClockOutput),
    .primaryFamily44k(primaryFamily44k), .secondaryFamily44k(secondaryFamily44k),
    .referenceThreePulldown(referenceThreePulldown));

  // clock at 200 MHz
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // loop pulses every other cycle so secondary and processor ticks are sparse
  always @(posedge mclk) begin
    tog <= rst_n ? ~tog : 1'b0;
  end

  task automatic tally_and_finish;
    if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [9:0] a, input logic [15:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {20'h0, a, 2'b00};
    pwdata <= {16'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_mismatch++;
      tally_and_finish;
    end
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [9:0] a, input logic [15:0] e, input logic ee);
    apb(1'b0, a, 16'h0);
    cmp("prdata", {16'h0, e}, rdv);
    cmp("pslverr", {31'h0, ee}, {31'h0, errv});
  endtask

  // port compare once the last write has settled; s picks the watched output, read only after the wait
  task automatic pin(input string nm, input logic e, input int s);
    logic g;
    repeat (2) @(posedge mclk);
    g = (s == 0) ? referenceThreePulldown : (s == 1) ? primaryFamily44k : secondaryFamily44k;
    cmp(nm, {31'h0, e}, {31'h0, g});
  endtask

  // cycles between two consecutive rises of a watched output
  task automatic gap(input int s, input int e);
    logic p, c;
    int k, first;
    p = 1'b1;
    first = -1;
    for (k = 0; k < 2000; k++) begin
      @(posedge mclk);
      c = (s == 0) ? slowClockTick : (s == 1) ? primaryClockOutput : secondaryClockOutput;
      if (c === 1'b1 && p === 1'b0) begin
        if (first >= 0) break;
        first = k;
      end
      p = c;
    end
    if (k >= 2000) begin
      n_mismatch++;
      tally_and_finish;
    end
    cmp("period", e, k - first);
  endtask

  // three pulses on the masked pins, bit clocks above references; s 0 counts slow ticks, 1 primary ticks
  task automatic pulses(input logic [5:0] m, input int s, input int e);
    int n;
    n = 0;
    repeat (3) begin
      {serialPortBitClock, referenceInput} <= m;
      repeat (4) @(posedge mclk) n += ((s == 0 ? slowClockTick : primaryCoreTick) === 1'b1);
      {serialPortBitClock, referenceInput} <= 6'h00;
      repeat (6) @(posedge mclk) n += ((s == 0 ? slowClockTick : primaryCoreTick) === 1'b1);
    end
    cmp("ticks", e, n);
  endtask

  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
    referenceInput = 3'b000;
    serialPortBitClock = 3'b000;
    lockLoopOneDoubledTick = 1'b1;
    lockLoopOneTick = 1'b0;
    n_mismatch = 0;
    comparisons = 0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    for (i = 0; i < 20; i++) rd(ridx[i], rval[i], 1'b0);
    rd(10'h1FF, 16'h0, 1'b1);
    wr(10'h10A, 16'h001F);
    rd(10'h10A, 16'h0000, 1'b0);
    for (i = 0; i < 20; i++) begin
      if (i <= 6 || (i >= 9 && i <= 14) || i >= 17) begin
        wr(10'h103, i[15:0]);
        rd(10'h103, i[15:0], 1'b0);
      end
    end
    wr(10'h14E, 16'h0200);
    pin("pulldown", 1'b1, 0);
    wr(10'h14E, 16'h0000);
    pin("pulldown", 1'b0, 0);
    wr(10'h102, 16'h000B);
    wr(10'h101, 16'h0444);
    rd(10'h10A, 16'h000B, 1'b0);
    rd(10'h10B, 16'h0013, 1'b0);
    pin("family", 1'b1, 1);
    wr(10'h102, 16'h0003);
    pin("family", 1'b0, 1);
    wr(10'h101, 16'h0404);
    wr(10'h101, 16'h8444);
    pin("family", 1'b1, 1);
    wr(10'h101, 16'h8404);
    wr(10'h101, 16'h0444);
    wr(10'h113, 16'h000D);
    wr(10'h112, 16'h0345);
    rd(10'h11B, 16'h000D, 1'b0);
    rd(10'h11C, 16'h0011, 1'b0);
    pin("sec family", 1'b1, 2);
    wr(10'h149, 16'h8030);
    gap(1, 6);
    wr(10'h149, 16'h80F0);
    gap(1, 30);
    wr(10'h14A, 16'h8010);
    gap(2, 4);
    wr(10'h122, 16'h1234);
    rd(10'h126, 16'h1234, 1'b0);
    wr(10'h120, 16'h0045);
    wr(10'h122, 16'h2000);
    rd(10'h126, 16'h1234, 1'b0);
    rd(10'h122, 16'h2000, 1'b0);
    wr(10'h120, 16'h0044);
    rd(10'h126, 16'h2000, 1'b0);
    rd(10'h127, 16'h0004, 1'b0);
    wr(10'h100, 16'h0040);
    pulses(6'h01, 0, 3);
    pulses(6'h02, 0, 0);
    wr(10'h100, 16'h0041);
    pulses(6'h02, 0, 3);
    wr(10'h100, 16'h0001);
    pulses(6'h02, 0, 0);
    wr(10'h101, 16'h0404);
    wr(10'h101, 16'h0044);
    wr(10'h100, 16'h0042);
    gap(0, 192);
    wr(10'h101, 16'h0004);
    wr(10'h101, 16'h8044);
    gap(0, 176);
    wr(10'h101, 16'h8145);
    gap(0, 704);
    lockLoopOneTick <= 1'b1;
    wr(10'h101, 16'h0048);
    pulses(6'h08, 1, 3);
    wr(10'h101, 16'h0042);
    pulses(6'h04, 1, 3);
    wr(10'h101, 16'h004F);
    pulses(6'h00, 1, 30);
    tally_and_finish;
  end
endmodule
